// ---- rtl/gss_top.sv ----
`timescale 1ns/1ns
// Operation
// - Shutdown pin pulled low at power-on
// - Release shutdown pin in hibernate, bits set
// - Wake range and sense bits, default 001
// - High bit fifteen enables reserve compensation
// - Sleep enable and capacity update bits
// - Shutdown pin drive style and polarity
// - Thermistor or on-chip temperature select
// - Charge overtemperature flag with hold time
// - Discharge overtemperature flag with hold time
// - Termination: two taper windows, three conditions
// - Termination clears charge, loads capacity
// - Alarm threshold minus one: taper sets
// - Full threshold minus one: taper sets
// - Charge inhibit with temperature hysteresis
// - Normal mode when nothing else active
// - Auto sleep when enabled, current low
// - Offset calibration before sleep entry
// - Stall lines up to four milliseconds
// - Leave sleep on current or wake
// - Deep sleep by command, comm exits
// - Deep sleep wait timer, zero disables
// - Oscillator stopped in deep sleep
// - Leaving hibernate clears hibernate bit
// - Sense bits zero disable wake comparator
module gss_top #(
  parameter int unsigned STALL_CYCLES = gss_pkg::STALL_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire gss_pkg::gss_meas_s MEAS_I,
  input wire logic MEAS_TICK_I,
  input wire logic TAPER_WIN_I,
  input wire logic SHDN_STORED_I,
  input wire logic HIB_VOLT_I,
  input wire logic HIB_CURR_I,
  input wire logic CAL_DONE_I,
  input wire logic COMM_ACT_I,
  output logic SHDN_O,
  output logic SHDN_OE_O,
  output logic HFOSC_EN_O,
  output logic CAL_START_O,
  output logic COMM_HOLD_O,
  output logic REMCAP_LOAD_O,
  output logic THERM_SEL_O,
  output logic RESERVE_NOLOAD_COMP_COMP_O,
  output logic [4:0] MODE_O
);
  import gss_pkg::*;

  // Bus and register state
  logic waitreq_r, waitreq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] pack_r, pack_nxt; // Setup word
  logic [2:0] ctrl_r, ctrl_nxt; // Shutdown, hibernate, deep sleep
  logic [31:0] cfg_r [CFG_N];
  logic [31:0] cfg_nxt [CFG_N];
  logic strap_r, strap_nxt; // Strap still to be taken

  // Mode state
  gss_mode_e mode_r, mode_nxt;
  logic [15:0] dtmr_r, dtmr_nxt; // Deep sleep wait countdown
  logic [15:0] hold_r, hold_nxt; // Line stall countdown
  logic cal_r, cal_nxt;
  logic hfosc_r, hfosc_nxt;
  logic hold_o_r, hold_o_nxt;
  logic shdn_r, shdn_nxt;
  logic shdn_oe_r, shdn_oe_nxt;
  logic leave_hib, leave_deep; // Hardware clears of control bits

  // Flag state
  logic [5:0] flg_r, flg_nxt;
  logic [15:0] ot_cnt_r [2];
  logic [15:0] ot_cnt_nxt [2];
  logic [1:0] tap_r, tap_nxt; // Qualified taper windows
  logic rcl_r, rcl_nxt;

  // Handy views of measurements and settings
  logic req, acc;
  logic [31:0] wmask;
  logic signed [15:0] temp, avg, sr;
  logic charging, dischg, below_sleep, above_sleep, wake_hit;
  logic [15:0] sr_abs;
  logic [2:0] wsel;

  assign temp = MEAS_I.temp;
  assign avg = MEAS_I.avg_curr;
  assign sr = MEAS_I.sr_volt;
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign acc = req & ~waitreq_r;
  assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                  {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign charging = avg > $signed(cfg_r[CI_CURR][15:0]);
  assign dischg = avg <= -$signed(cfg_r[CI_CURR][31:16]);
  assign below_sleep = avg < $signed(cfg_r[CI_SLEEP][15:0]);
  assign above_sleep = avg > $signed(cfg_r[CI_SLEEP][15:0]);
  assign sr_abs = sr[15] ? 16'(-sr) : 16'(sr);
  assign wsel = {pack_r[PB_RSHI], pack_r[PB_RSLO], pack_r[PB_WRANGE]};
  // Sense bits both zero select no threshold at all
  assign wake_hit = (wsel[2:1] != 2'h0) && (sr_abs > wake_thr(wsel));

  // Next state of bus answer and registers
  always_comb begin
    int unsigned idx;
    idx = 0;
    waitreq_nxt = 1'b1;
    rdata_nxt = rdata_r;
    pack_nxt = pack_r;
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    strap_nxt = 1'b0;
    // Take the stored shutdown bit once after reset
    if (strap_r) begin
      ctrl_nxt[CB_SHDN] = SHDN_STORED_I;
    end
    // Hardware clears come first so software sets win
    if (leave_hib) begin
      ctrl_nxt[CB_HIB] = 1'b0;
    end
    if (leave_deep) begin
      ctrl_nxt[CB_DEEP] = 1'b0;
    end
    // Word index into the threshold block
    if (AVS_ADDRESS_I >= OFS_CFG && AVS_ADDRESS_I <= OFS_LAST) begin
      idx = 32'(AVS_ADDRESS_I - OFS_CFG) >> 2;
    end
    // One wait cycle; read data loaded now so it stands with waitrequest low
    if (req && waitreq_r) begin
      waitreq_nxt = 1'b0;
      rdata_nxt = '0;
      case (AVS_ADDRESS_I)
        OFS_PACK: begin
          rdata_nxt = {16'h0000, pack_r};
        end
        OFS_CTRL: begin
          rdata_nxt = {29'h0000_0000, ctrl_r};
        end
        OFS_FLAGS: begin
          rdata_nxt[5:0] = flg_r;
          rdata_nxt[FB_MODE +: 5] = mode_r;
        end
        default: begin
          // Threshold block or unmapped
          if (AVS_ADDRESS_I >= OFS_CFG && AVS_ADDRESS_I <= OFS_LAST &&
              AVS_ADDRESS_I[1:0] == 2'h0) begin
            rdata_nxt = cfg_r[idx];
          end
        end
      endcase
    end
    // Writes land at the edge that completes the access
    if (acc && AVS_WRITE_I) begin
      case (AVS_ADDRESS_I)
        OFS_PACK: begin
          pack_nxt = (pack_r & ~wmask[15:0]) | (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
        end
        OFS_CTRL: begin
          if (AVS_BYTEENABLE_I[0]) begin
            ctrl_nxt[CB_SHDN] = AVS_WRITEDATA_I[CB_SHDN];
            // Software may set hibernate request
            if (AVS_WRITEDATA_I[CB_HIB]) begin
              ctrl_nxt[CB_HIB] = 1'b1;
            end
            // Deep sleep command sets only
            if (AVS_WRITEDATA_I[CB_DEEP]) begin
              ctrl_nxt[CB_DEEP] = 1'b1;
            end
          end
        end
        default: begin
          // Threshold block; flags and unmapped words ignore writes
          if (AVS_ADDRESS_I >= OFS_CFG && AVS_ADDRESS_I <= OFS_LAST &&
              AVS_ADDRESS_I[1:0] == 2'h0) begin
            cfg_nxt[idx] = (cfg_r[idx] & ~wmask) | (AVS_WRITEDATA_I & wmask);
          end
        end
      endcase
    end
  end

  // Registers for the bus group
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      waitreq_r <= 1'b1;
      rdata_r <= '0;
      pack_r <= PACK_RST;
      ctrl_r <= '0;
      strap_r <= 1'b1;
      for (int i = 0; i < CFG_N; i++) begin
        cfg_r[i] <= '0;
      end
    end else begin
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
      pack_r <= pack_nxt;
      ctrl_r <= ctrl_nxt;
      strap_r <= strap_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Next state of the power mode machine
  always_comb begin
    logic shdn_act, lvl;
    shdn_act = 1'b0;
    lvl = 1'b0;
    mode_nxt = mode_r;
    dtmr_nxt = dtmr_r;
    hold_nxt = hold_r;
    cal_nxt = 1'b0;
    leave_hib = 1'b0;
    leave_deep = 1'b0;
    case (mode_r)
      MD_NORMAL: begin
        // Measuring and deciding happen here
        if (HIB_VOLT_I || (HIB_CURR_I && ctrl_r[CB_HIB])) begin
          mode_nxt = MD_HIB;
        end else if (pack_r[PB_SLEEP] && below_sleep) begin
          mode_nxt = MD_CALIB;
          cal_nxt = 1'b1;
        end
      end
      MD_CALIB: begin
        // Entry broken while calibrating
        if (!pack_r[PB_SLEEP] || !below_sleep || wake_hit) begin
          mode_nxt = MD_NORMAL;
        end else if (CAL_DONE_I) begin
          mode_nxt = MD_SLEEP;
          dtmr_nxt = cfg_r[CI_SLEEP][31:16];
        end
      end
      MD_SLEEP: begin
        if (above_sleep || wake_hit) begin
          mode_nxt = MD_NORMAL;
        end else if (HIB_VOLT_I || (HIB_CURR_I && ctrl_r[CB_HIB])) begin
          mode_nxt = MD_HIB;
        end else if (ctrl_r[CB_DEEP]) begin
          mode_nxt = MD_DEEP;
        end else if (cfg_r[CI_SLEEP][31:16] != 16'h0000) begin
          // Countdown runs on measurement ticks
          if (dtmr_r == 16'h0000) begin
            mode_nxt = MD_DEEP;
          end else if (MEAS_TICK_I) begin
            dtmr_nxt = dtmr_r - 16'h0001;
          end
        end
      end
      MD_DEEP: begin
        // Serial activity or wake condition ends it
        if (COMM_ACT_I || above_sleep || wake_hit) begin
          mode_nxt = MD_NORMAL;
          leave_deep = 1'b1;
        end
      end
      MD_HIB: begin
        if (COMM_ACT_I) begin
          mode_nxt = MD_NORMAL;
          leave_hib = 1'b1;
        end
      end
      default: begin
        mode_nxt = MD_NORMAL;
      end
    endcase
    // Line stall while the core is mostly halted
    if (hold_r != 16'h0000) begin
      hold_nxt = hold_r - 16'h0001;
    end else if (COMM_ACT_I && (mode_r == MD_SLEEP || mode_r == MD_DEEP)) begin
      hold_nxt = 16'(STALL_CYCLES);
    end
    hold_o_nxt = hold_nxt != 16'h0000;
    hfosc_nxt = mode_nxt != MD_DEEP && mode_nxt != MD_HIB;
    // Pin shows ready for shutdown only in hibernate
    shdn_act = mode_nxt == MD_HIB && ctrl_nxt[CB_HIB] && ctrl_nxt[CB_SHDN];
    lvl = shdn_act ? pack_nxt[PB_POL] : ~pack_nxt[PB_POL];
    shdn_nxt = lvl;
    // Open drain lets a high level float
    shdn_oe_nxt = pack_nxt[PB_PUSHPULL] | ~lvl;
  end

  // Registers for the mode group
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      mode_r <= MD_NORMAL;
      dtmr_r <= '0;
      hold_r <= '0;
      cal_r <= 1'b0;
      hfosc_r <= 1'b1;
      hold_o_r <= 1'b0;
      shdn_r <= 1'b0;
      shdn_oe_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      dtmr_r <= dtmr_nxt;
      hold_r <= hold_nxt;
      cal_r <= cal_nxt;
      hfosc_r <= hfosc_nxt;
      hold_o_r <= hold_o_nxt;
      shdn_r <= shdn_nxt;
      shdn_oe_r <= shdn_oe_nxt;
    end
  end

  // Next state of flags and timers
  always_comb begin
    logic hit, term;
    logic signed [15:0] thr, rec;
    logic [15:0] tim;
    hit = 1'b0;
    term = 1'b0;
    thr = '0;
    rec = '0;
    tim = '0;
    flg_nxt = flg_r;
    ot_cnt_nxt = ot_cnt_r;
    tap_nxt = tap_r;
    rcl_nxt = 1'b0;
    if (MEAS_TICK_I && mode_r != MD_HIB) begin
      // Both overtemperature checks share one shape
      for (int i = 0; i < 2; i++) begin
        thr = $signed(cfg_r[CI_OTC + i][15:0]);
        rec = $signed(cfg_r[CI_OTC + i][31:16]);
        tim = i == 0 ? cfg_r[CI_OTTIME][15:0] : cfg_r[CI_OTTIME][31:16];
        hit = (i == 0 ? charging : dischg) && temp >= thr;
        if (tim == 16'h0000 || temp <= rec) begin
          ot_cnt_nxt[i] = '0;
          flg_nxt[FB_OTC + i] = 1'b0;
        end else if (hit) begin
          if (ot_cnt_r[i] < tim) begin
            ot_cnt_nxt[i] = ot_cnt_r[i] + 16'h0001;
          end
          if (ot_cnt_nxt[i] >= tim) begin
            flg_nxt[FB_OTC + i] = 1'b1;
          end
        end else begin
          ot_cnt_nxt[i] = '0;
        end
      end
      // Inhibit band with hysteresis
      if (temp < $signed(cfg_r[CI_INH][15:0]) || temp > $signed(cfg_r[CI_INH][31:16])) begin
        flg_nxt[FB_INH] = 1'b1;
      end else if (temp >= $signed(cfg_r[CI_INH][15:0]) + $signed(cfg_r[CI_HYSTAP][15:0]) &&
                   temp <= $signed(cfg_r[CI_INH][31:16]) - $signed(cfg_r[CI_HYSTAP][15:0])) begin
        flg_nxt[FB_INH] = 1'b0;
      end
      // Charge flag holds until termination
      if (charging && tap_r != TAPER_WINS) begin
        flg_nxt[FB_CHG] = 1'b1;
      end
      // Threshold driven alarm and full flags
      if (cfg_r[CI_TCAFC][15:0] != THR_OFF && MEAS_I.soc >= cfg_r[CI_TCAFC][15:0]) begin
        flg_nxt[FB_TERM] = 1'b1;
      end
      if (cfg_r[CI_TCAFC][31:16] != THR_OFF && MEAS_I.soc >= cfg_r[CI_TCAFC][31:16]) begin
        flg_nxt[FB_FULL] = 1'b1;
      end
      if (dischg) begin
        flg_nxt[FB_TERM] = 1'b0;
        flg_nxt[FB_FULL] = 1'b0;
        tap_nxt = '0;
      end
    end
    // Taper windows counted at each window end
    if (TAPER_WIN_I && mode_r != MD_HIB) begin
      if (avg < $signed(cfg_r[CI_HYSTAP][31:16]) && MEAS_I.dcap > DCAP_MIN &&
          int'(MEAS_I.volt) > int'(cfg_r[CI_VOLT][15:0]) - int'(cfg_r[CI_VOLT][31:16])) begin
        if (tap_r != TAPER_WINS) begin
          tap_nxt = tap_r + 2'h1;
          term = tap_nxt == TAPER_WINS;
        end
      end else begin
        tap_nxt = '0;
      end
    end
    // Termination effects
    if (term) begin
      flg_nxt[FB_CHG] = 1'b0;
      rcl_nxt = pack_r[PB_REMCAP_LOAD_ON_TERM];
      if (cfg_r[CI_TCAFC][15:0] == THR_OFF) begin
        flg_nxt[FB_TERM] = 1'b1;
      end
      if (cfg_r[CI_TCAFC][31:16] == THR_OFF) begin
        flg_nxt[FB_FULL] = 1'b1;
      end
    end
  end

  // Registers for the flag group
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      flg_r <= '0;
      ot_cnt_r[0] <= '0;
      ot_cnt_r[1] <= '0;
      tap_r <= '0;
      rcl_r <= 1'b0;
    end else begin
      flg_r <= flg_nxt;
      ot_cnt_r <= ot_cnt_nxt;
      tap_r <= tap_nxt;
      rcl_r <= rcl_nxt;
    end
  end

  // Outputs straight from flops
  assign AVS_READDATA_O = rdata_r;
  assign AVS_WAITREQUEST_O = waitreq_r;
  assign SHDN_O = shdn_r;
  assign SHDN_OE_O = shdn_oe_r;
  assign HFOSC_EN_O = hfosc_r;
  assign CAL_START_O = cal_r;
  assign COMM_HOLD_O = hold_o_r;
  assign REMCAP_LOAD_O = rcl_r;
  assign THERM_SEL_O = pack_r[PB_THERM];
  assign RESERVE_NOLOAD_COMP_COMP_O = pack_r[PB_RESERVE_NOLOAD_COMP];
  assign MODE_O = mode_r;
endmodule

// ---- rtl/gss_pkg.sv ----
package gss_pkg;
  // Clock rate and stall window
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned STALL_US = 4000;
  localparam int unsigned STALL_CYC = STALL_US * (CLK_HZ / 1_000_000);

  // Register byte offsets
  localparam logic [5:0] OFS_PACK = 6'h00;
  localparam logic [5:0] OFS_CTRL = 6'h04;
  localparam logic [5:0] OFS_FLAGS = 6'h08;
  localparam logic [5:0] OFS_CFG = 6'h0C;
  localparam int unsigned CFG_N = 9;
  localparam logic [5:0] OFS_LAST = 6'h2C;

  // Indices into the threshold block
  localparam int CI_OTC = 0;
  localparam int CI_OTD = 1;
  localparam int CI_OTTIME = 2;
  localparam int CI_CURR = 3;
  localparam int CI_INH = 4;
  localparam int CI_HYSTAP = 5;
  localparam int CI_VOLT = 6;
  localparam int CI_SLEEP = 7;
  localparam int CI_TCAFC = 8;

  // Setup word reset and field positions
  localparam logic [15:0] PACK_RST = 16'h0135;
  localparam int PB_RESERVE_NOLOAD_COMP = 15;
  localparam int PB_WRANGE = 10;
  localparam int PB_RSHI = 9;
  localparam int PB_RSLO = 8;
  localparam int PB_SLEEP = 5;
  localparam int PB_REMCAP_LOAD_ON_TERM = 4;
  localparam int PB_PUSHPULL = 3;
  localparam int PB_POL = 2;
  localparam int PB_THERM = 0;

  // Control word fields
  localparam int CB_SHDN = 0;
  localparam int CB_HIB = 1;
  localparam int CB_DEEP = 2;

  // Flag word fields
  localparam int FB_OTC = 0;
  localparam int FB_OTD = 1;
  localparam int FB_INH = 2;
  localparam int FB_CHG = 3;
  localparam int FB_TERM = 4;
  localparam int FB_FULL = 5;
  localparam int FB_MODE = 8;

  // Termination figures
  localparam logic [1:0] TAPER_WINS = 2'h2;
  localparam logic [15:0] DCAP_MIN = 16'h0019;
  localparam logic [15:0] THR_OFF = 16'hFFFF;

  // Wake thresholds in 10 uV units
  localparam logic [15:0] WK_1P25 = 16'h007D;
  localparam logic [15:0] WK_2P5 = 16'h00FA;
  localparam logic [15:0] WK_5 = 16'h01F4;
  localparam logic [15:0] WK_10 = 16'h03E8;

  // Power modes
  typedef enum logic [4:0] {
    MD_NORMAL = 5'b0_0001,
    MD_CALIB = 5'b0_0010,
    MD_SLEEP = 5'b0_0100,
    MD_DEEP = 5'b0_1000,
    MD_HIB = 5'b1_0000
  } gss_mode_e;

  // Measurement set from the gauging core
  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] avg_curr;
    logic [15:0] volt;
    logic [15:0] soc;
    logic [15:0] dcap;
    logic signed [15:0] sr_volt;
  } gss_meas_s;

  // Wake comparator level from selection bits
  function automatic logic [15:0] wake_thr(input logic [2:0] sel);
    case (sel)
      3'h2: wake_thr = WK_1P25;
      3'h3: wake_thr = WK_2P5;
      3'h4: wake_thr = WK_2P5;
      3'h5: wake_thr = WK_5;
      3'h6: wake_thr = WK_5;
      3'h7: wake_thr = WK_10;
      default: wake_thr = THR_OFF;
    endcase
  endfunction
endpackage

// ---- tb/gss_top_assertions.sv ----
`timescale 1ns/1ns
module gss_top_assertions
  import gss_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = 20
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic TAPER_WIN_I,
  input wire logic COMM_ACT_I,
  input wire logic SHDN_O,
  input wire logic SHDN_OE_O,
  input wire logic HFOSC_EN_O,
  input wire logic CAL_START_O,
  input wire logic COMM_HOLD_O,
  input wire logic REMCAP_LOAD_O,
  input wire logic [4:0] MODE_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SRST_I);
  logic [31:0] hold_cnt_r; // Length of the current stall
  logic [31:0] hold_cnt_nxt; // Next stall length
  // Count consecutive stall cycles
  always_comb begin
    hold_cnt_nxt = COMM_HOLD_O ? hold_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end
  // Register the stall count
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      hold_cnt_r <= 32'h0000_0000;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
    end
  end
  // Normal mode handing over to calibration
  sequence s_norm_cal;
    MODE_O == MD_NORMAL ##1 MODE_O == MD_CALIB;
  endsequence
  // Serial activity seen in deep sleep
  sequence s_deep_wake;
    MODE_O == MD_DEEP && COMM_ACT_I;
  endsequence
  a_one_mode: assert property ($onehot(MODE_O))
    else $error("mode not one-hot");
  a_cal_start_pulse: assert property (s_norm_cal |-> CAL_START_O ##1 !CAL_START_O)
    else $error("calibration start missing");
  a_sleep_via_cal: assert property ($rose(MODE_O == MD_SLEEP) |-> $past(MODE_O) == MD_CALIB)
    else $error("sleep without calibration");
  a_osc_stop: assert property (HFOSC_EN_O == !(MODE_O inside {MD_DEEP, MD_HIB}))
    else $error("oscillator enable wrong");
  a_hold_rise: assert property (COMM_ACT_I && MODE_O inside {MD_SLEEP, MD_DEEP} |=> COMM_HOLD_O)
    else $error("stall not raised");
  a_hold_bound: assert property (hold_cnt_r <= STALL_CYCLES)
    else $error("stall too long");
  a_deep_wake: assert property (s_deep_wake |=> MODE_O == MD_NORMAL)
    else $error("deep sleep not left");
  a_pin_at_por: assert property ($fell(SRST_I) |-> !SHDN_O && SHDN_OE_O)
    else $error("shutdown pin not low");
  a_remcap_pulse: assert property (REMCAP_LOAD_O |-> $past(TAPER_WIN_I) ##1 !REMCAP_LOAD_O)
    else $error("capacity load pulse wrong");
endmodule

// ---- tb/gss_host_model.sv ----
`timescale 1ns/1ns
module gss_host_model #(
  parameter int CAL_DLY = 5
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cal_start_i,
  input wire logic comm_hold_i,
  input wire logic comm_req_i,
  output logic cal_done_o,
  output logic comm_act_o,
  output logic comm_wait_o
);
  int cal_cnt; // Cycles left in offset calibration
  logic pending_r; // Transfer waiting for the lines
  assign comm_wait_o = pending_r;
  // Calibration engine and host transfer start
  always_ff @(posedge clk_i) begin
    cal_done_o <= 1'b0;
    comm_act_o <= 1'b0;
    if (srst_i) begin
      cal_cnt <= 0;
      pending_r <= 1'b0;
    end else begin
      if (cal_start_i) begin
        cal_cnt <= CAL_DLY;
      end else if (cal_cnt > 0) begin
        cal_cnt <= cal_cnt - 1;
      end
      if (cal_cnt == 1) begin
        cal_done_o <= 1'b1;
      end
      if (comm_req_i) begin
        pending_r <= 1'b1;
      end else if (pending_r && !comm_hold_i) begin
        comm_act_o <= 1'b1;
        pending_r <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/gss_top_tb.sv ----
`timescale 1ns/1ns
module gss_top_tb;
  import gss_pkg::*;
  logic clk, srst, rd, wr, tick, win, hv, creq, wait_o, shdn, shdn_oe, hfosc;
  logic cal_st, hold, remcap, therm, reserve_noload_comp, cal_dn, cact, cwait;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, got;
  logic [4:0] mode;
  gss_meas_s meas;
  int fail_count, total_checks, cyc;
  gss_top #(.STALL_CYCLES(20)) dut_u (.REF_CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o), .MEAS_I(meas), .MEAS_TICK_I(tick),
    .TAPER_WIN_I(win), .SHDN_STORED_I(1'b1), .HIB_VOLT_I(hv), .HIB_CURR_I(1'b0),
    .CAL_DONE_I(cal_dn), .COMM_ACT_I(cact), .SHDN_O(shdn), .SHDN_OE_O(shdn_oe),
    .HFOSC_EN_O(hfosc), .CAL_START_O(cal_st), .COMM_HOLD_O(hold), .REMCAP_LOAD_O(remcap),
    .THERM_SEL_O(therm), .RESERVE_NOLOAD_COMP_COMP_O(reserve_noload_comp), .MODE_O(mode));
  gss_host_model #(.CAL_DLY(5)) host_u (.clk_i(clk), .srst_i(srst), .cal_start_i(cal_st),
    .comm_hold_i(hold), .comm_req_i(creq), .cal_done_o(cal_dn), .comm_act_o(cact),
    .comm_wait_o(cwait));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One register access, held until waitrequest drops
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (wait_o !== 1'b0) @(posedge clk);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_tick(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic win_pulse(input logic exp_load);
    win <= 1'b1;
    @(posedge clk);
    win <= 1'b0;
    @(negedge clk);
    check(remcap, exp_load);
    @(posedge clk);
  endtask
  task automatic wait_mode(input logic [4:0] m);
    for (int i = 0; i < 300 && mode !== m; i++) @(posedge clk);
    check(mode, m);
  endtask
  task automatic comm();
    creq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 100 && cwait !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic t_reset();
    check({shdn, shdn_oe}, 2'b01);
    check(mode, MD_NORMAL);
    bus(1'b0, OFS_PACK, 32'h0000_0000);
    check(got[15:0], 16'h0135);
    check({therm, reserve_noload_comp}, 2'b10);
    bus(1'b0, 6'h30, 32'h0000_0000);
    check(got, 32'h0000_0000);
  endtask
  task automatic t_setup();
    bus(1'b1, OFS_PACK, 32'h0000_8000);
    @(negedge clk);
    check({therm, reserve_noload_comp}, 2'b01);
    @(posedge clk);
    bus(1'b1, OFS_PACK, 32'h0000_0115);
    bus(1'b0, OFS_PACK, 32'h0000_0000);
    check(got[15:0], 16'h0115);
  endtask
  task automatic t_overtemp();
    bus(1'b1, 6'h0C, 32'h0028_0032);
    bus(1'b1, 6'h14, 32'h0000_0002);
    bus(1'b1, 6'h18, 32'h0000_000A);
    meas.temp <= 16'h0037;
    meas.avg_curr <= 16'h0014;
    pulse_tick(1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[0], 1'b0);
    pulse_tick(1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[0], 1'b1);
    meas.temp <= 16'h001E;
    pulse_tick(1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[0], 1'b0);
    meas.temp <= 16'h003C;
    meas.avg_curr <= 16'hFFEC;
    pulse_tick(3);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[1], 1'b0);
  endtask
  task automatic t_term();
    bus(1'b1, 6'h20, 32'h0032_0000);
    bus(1'b1, 6'h24, 32'h0064_1068);
    bus(1'b1, 6'h2C, 32'hFFFF_FFFF);
    meas <= '{16'h0019, 16'h0014, 16'h1036, 16'h0000, 16'h001E, 16'h0000};
    pulse_tick(1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[5], 1'b0);
    win_pulse(1'b0);
    win_pulse(1'b1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    check(got[5:3], 3'b110);
  endtask
  task automatic deep_out();
    comm();
    wait_mode(MD_NORMAL);
    meas.avg_curr <= 16'h00C8;
    check(hold, 1'b1);
    for (int i = 0; i < 40 && hold !== 1'b0; i++) @(posedge clk);
    check(hold, 1'b0);
  endtask
  task automatic t_sleep();
    bus(1'b1, OFS_PACK, 32'h0000_0135);
    bus(1'b1, 6'h28, 32'h0000_0064);
    meas.avg_curr <= 16'h0005;
    pulse_tick(1);
    wait_mode(MD_CALIB);
    wait_mode(MD_SLEEP);
    meas.avg_curr <= 16'h00C8;
    pulse_tick(1);
    wait_mode(MD_NORMAL);
    meas.avg_curr <= 16'h0005;
    pulse_tick(1);
    wait_mode(MD_SLEEP);
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    wait_mode(MD_DEEP);
    check(hfosc, 1'b0);
    deep_out();
    bus(1'b0, OFS_CTRL, 32'h0000_0000);
    check(got[2], 1'b0);
    bus(1'b1, 6'h28, 32'h0003_0064);
    meas.avg_curr <= 16'h0005;
    pulse_tick(1);
    wait_mode(MD_SLEEP);
    pulse_tick(4);
    wait_mode(MD_DEEP);
    deep_out();
  endtask
  task automatic t_hib();
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    hv <= 1'b1;
    wait_mode(MD_HIB);
    @(negedge clk);
    check(shdn_oe, 1'b0);
    @(posedge clk);
    hv <= 1'b0;
    comm();
    wait_mode(MD_NORMAL);
    bus(1'b0, OFS_CTRL, 32'h0000_0000);
    check(got[1:0], 2'b01);
  endtask
  // Main sequence
  initial begin
    {srst, rd, wr, tick, win, hv, creq} = 7'h40;
    adr = 6'h00;
    wdat = 32'h0000_0000;
    meas = '0;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_setup();
    t_overtemp();
    t_term();
    t_sleep();
    t_hib();
    close_out();
  end
endmodule
bind gss_top gss_top_assertions #(.STALL_CYCLES(STALL_CYCLES)) chk_u (.REF_CLK_I(REF_CLK_I),
  .SRST_I(SRST_I), .TAPER_WIN_I(TAPER_WIN_I), .COMM_ACT_I(COMM_ACT_I), .SHDN_O(SHDN_O),
  .SHDN_OE_O(SHDN_OE_O), .HFOSC_EN_O(HFOSC_EN_O), .CAL_START_O(CAL_START_O),
  .COMM_HOLD_O(COMM_HOLD_O), .REMCAP_LOAD_O(REMCAP_LOAD_O), .MODE_O(MODE_O));
